// ### hdl/analog_ctl_pkg.sv
// Package: register map, field positions and reset values of the analog control
package analog_ctl_pkg;

  // ==========================================================================
  // Register bus geometry
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;

  // ==========================================================================
  // Register offsets
  localparam logic [12:0] OFS_ANALOG_MUX = 13'h0003;
  localparam logic [12:0] OFS_IRQ_MASK = 13'h001C;
  localparam logic [12:0] OFS_ANALOG_CONTROL = 13'h001D;
  localparam logic [12:0] OFS_ANALOG_STATUS = 13'h001E;
  localparam logic [12:0] OFS_WATCHDOG_SECURITY = 13'h1FF0;

  // ==========================================================================
  // Analog multiplex register fields
  localparam int MUX_CHAN_LSB = 0;
  localparam int MUX_CHAN_W = 4;
  localparam int MUX_SWAP_BIT = 4;
  localparam int MUX_SUPPLY_REF_BIT = 5;
  localparam int MUX_DIVIDED_HOLD_BIT = 6;
  localparam int MUX_HOLD_BIT = 7;

  // ==========================================================================
  // Analog control register fields
  localparam int CTL_METHOD1_BIT = 0;
  localparam int CTL_METHOD2_BIT = 1;
  localparam int CTL_CHARGE_BIT = 2;
  localparam int CTL_RAMP_SRC_BIT = 3;
  localparam int CTL_DISCHARGE_BIT = 4;

  // ==========================================================================
  // Analog status register fields (flags share layout with the mask)
  localparam int STS_CMP1_FLAG_BIT = 0;
  localparam int STS_CMP2_FLAG_BIT = 1;
  localparam int STS_OFFSET_EN_BIT = 4;
  localparam int STS_CMP1_DRIVE_BIT = 5;
  localparam int STS_CMP1_LEVEL_BIT = 6;
  localparam int STS_CMP2_LEVEL_BIT = 7;
  localparam int NUM_FLAGS = 2;

  // ==========================================================================
  // Watchdog and security register fields
  localparam int SEC_OPT_FEATURES_BIT = 0;

  // ==========================================================================
  // Synchronised input channels
  localparam int SYNC_CMP1 = 0;
  localparam int SYNC_CMP2 = 1;
  localparam int SYNC_CAPTURE_PIN = 2;
  localparam int NUM_SYNC = 3;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_ANALOG_MUX = 8'h00;
  localparam logic [7:0] RST_ANALOG_CONTROL = 8'h00;
  localparam logic [7:0] RST_STATUS_CTL = 8'h00;
  localparam logic [1:0] RST_FLAGS = 2'h0;
  localparam logic [1:0] RST_MASK = 2'h0;
  localparam logic RST_OPT_FEATURES = 1'b0;

endpackage

// ### hdl/analog_sync_if.sv
// Interface: synchronised comparator and pin levels with their rising pulses
interface analog_sync_if;
  logic [analog_ctl_pkg::NUM_SYNC-1:0] level;
  logic [analog_ctl_pkg::NUM_SYNC-1:0] rise;
  logic [analog_ctl_pkg::NUM_SYNC-1:0] change;

  modport src (output level, output rise, output change);
  modport dst (input level, input rise, input change);
endinterface

// ### hdl/analog_input_sync.sv
// Two-flop synchroniser and edge detector for each asynchronous analog input
module analog_input_sync #(
  parameter int N = 3
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Raw levels from comparators and pins
  input wire logic [N-1:0] i_raw,
  // Synchronised levels and edges
  analog_sync_if.src o_sync
);

  // ==========================================================================
  // One synchroniser per input
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_chan
      logic meta_ff;
      logic sync_ff;
      logic last_ff;

      // First stage is read only by the second stage
      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
        end else begin
          meta_ff <= i_raw[g];
          sync_ff <= meta_ff;
        end
      end

      // Previous synchronised level for edge detection
      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          last_ff <= 1'b0;
        end else begin
          last_ff <= sync_ff;
        end
      end

      assign o_sync.level[g] = sync_ff;
      assign o_sync.rise[g] = sync_ff & ~last_ff;
      assign o_sync.change[g] = sync_ff ^ last_ff;
    end
  endgenerate

endmodule

// ### hdl/analog_mux_comparator_control.sv
// Analog front end control: channel routing, comparators, ramp source, wake
// How it works
// - Supply reference bit with zero channel bits routes bus to supply pin.
// - Divided-hold bit without hold samples the half-divided version of the selected input.
// - Nonzero channel bits route the bus to one of four analog port pins.
// - Comparators work in wait mode; their interrupt can restart the core.
// - In stop mode comparators run but never directly request a wake.
// - Changes on the shared comparator 1 pin also trigger timer captures.
// - With options and drive on, pin output is comparator OR data OR level.
// - Option bit enables comparator pin drive and sample offset; 0 disables.
// - Clearing ramp source enable turns off current source and discharge.
// - With ramp source enabled the discharge device may pull the pin low.
// - Current source drives when enabled, manual mode 0, charge enabled, and no discharge request.
// - Hold and divided-hold together select the temperature sensing diode.
// - Temperature diode bias is on only while the diode is selected.
// - Active offset is steered by the hold and divided-hold bits.
//
// Decided for this implementation: strobed register access.
module analog_mux_comparator_control (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Register port
  input wire logic [analog_ctl_pkg::ADDR_W-1:0] i_addr,
  input wire logic [analog_ctl_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [analog_ctl_pkg::DATA_W-1:0] o_rdata,
  // Analog and pin inputs (asynchronous)
  input wire logic i_cmp1_out,
  input wire logic i_cmp2_out,
  input wire logic i_capture_pin,
  // Same-clock inputs from core, port and timer
  input wire logic i_wait_mode,
  input wire logic i_stop_mode,
  input wire logic i_pb4_data,
  input wire logic i_timer_output_level,
  // Interrupt and wake
  output logic o_irq,
  output logic o_wake_request,
  // Channel routing
  output logic o_route_supply,
  output logic [3:0] o_route_pin,
  output logic o_sel_direct,
  output logic o_sel_divided,
  output logic o_sel_temp_diode,
  output logic o_diode_bias_en,
  output logic o_comparator_input_swap,
  // Sample offset
  output logic o_offset_enable,
  output logic o_offset_hold,
  output logic o_offset_divided,
  // Ramp source
  output logic o_current_source_en,
  output logic o_discharge_en,
  // Port pin and timer
  output logic o_pb4_out,
  output logic o_timer_capture_event
);
  import analog_ctl_pkg::*;

  // ==========================================================================
  // Register state
  logic [7:0] analog_mux_reg_ff;
  logic [7:0] analog_control_reg_ff;
  logic [1:0] status_flags_ff;
  logic [1:0] irq_mask_ff;
  logic offset_en_ff;
  logic cmp1_drive_ff;
  logic optional_features_ff;
  logic [7:0] rdata_ff;
  logic [NUM_FLAGS-1:0] event_set;
  logic [NUM_FLAGS-1:0] nxt_flags;
  logic [7:0] status_view;
  logic [7:0] nxt_rdata;
  logic wr_mux;
  logic wr_ctl;
  logic wr_sts;
  logic wr_mask;
  logic wr_sec;

  // Field aliases
  logic hold;
  logic divided_hold;
  logic supply_ref;
  logic [3:0] channel_select_bits;
  logic ramp_source_enable;
  logic charge_enable;
  logic conv_method_bit1;
  logic conv_method_bit2;
  logic discharge_request;
  logic pb4_drive_on;

  // ==========================================================================
  // Synchronised comparator outputs and capture pin
  analog_sync_if sync_bus ();

  analog_input_sync #(
    .N(NUM_SYNC)
  ) u_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_raw({i_capture_pin, i_cmp2_out, i_cmp1_out}),
    .o_sync(sync_bus.src)
  );

  // ==========================================================================
  // Address decode
  assign wr_mux = i_wr && (i_addr == OFS_ANALOG_MUX);
  assign wr_ctl = i_wr && (i_addr == OFS_ANALOG_CONTROL);
  assign wr_sts = i_wr && (i_addr == OFS_ANALOG_STATUS);
  assign wr_mask = i_wr && (i_addr == OFS_IRQ_MASK);
  assign wr_sec = i_wr && (i_addr == OFS_WATCHDOG_SECURITY);

  // Field extraction
  assign hold = analog_mux_reg_ff[MUX_HOLD_BIT];
  assign divided_hold = analog_mux_reg_ff[MUX_DIVIDED_HOLD_BIT];
  assign supply_ref = analog_mux_reg_ff[MUX_SUPPLY_REF_BIT];
  assign channel_select_bits = analog_mux_reg_ff[MUX_CHAN_LSB +: MUX_CHAN_W];
  assign ramp_source_enable = analog_control_reg_ff[CTL_RAMP_SRC_BIT];
  assign charge_enable = analog_control_reg_ff[CTL_CHARGE_BIT];
  assign conv_method_bit1 = analog_control_reg_ff[CTL_METHOD1_BIT];
  assign conv_method_bit2 = analog_control_reg_ff[CTL_METHOD2_BIT];
  assign discharge_request = analog_control_reg_ff[CTL_DISCHARGE_BIT];

  // ==========================================================================
  // Analog multiplex register
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      analog_mux_reg_ff <= RST_ANALOG_MUX;
    end else if (wr_mux) begin
      analog_mux_reg_ff <= i_wdata;
    end
  end

  // Analog control register
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      analog_control_reg_ff <= RST_ANALOG_CONTROL;
    end else if (wr_ctl) begin
      analog_control_reg_ff <= i_wdata;
    end
  end

  // Writable status controls: offset enable and comparator pin drive
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      offset_en_ff <= RST_STATUS_CTL[STS_OFFSET_EN_BIT];
      cmp1_drive_ff <= RST_STATUS_CTL[STS_CMP1_DRIVE_BIT];
    end else if (wr_sts) begin
      offset_en_ff <= i_wdata[STS_OFFSET_EN_BIT];
      cmp1_drive_ff <= i_wdata[STS_CMP1_DRIVE_BIT];
    end
  end

  // Optional features bit
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      optional_features_ff <= RST_OPT_FEATURES;
    end else if (wr_sec) begin
      optional_features_ff <= i_wdata[SEC_OPT_FEATURES_BIT];
    end
  end

  // Interrupt mask
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      irq_mask_ff <= RST_MASK;
    end else if (wr_mask) begin
      irq_mask_ff <= i_wdata[NUM_FLAGS-1:0];
    end
  end

  // ==========================================================================
  // Comparator event flags: rising outputs set, write one clears, set wins.
  // Comparators keep running in wait and stop modes alike.
  assign event_set[STS_CMP1_FLAG_BIT] = sync_bus.rise[SYNC_CMP1];
  assign event_set[STS_CMP2_FLAG_BIT] = sync_bus.rise[SYNC_CMP2];

  always_comb begin
    nxt_flags = status_flags_ff;
    if (wr_sts) begin
      nxt_flags = nxt_flags & ~i_wdata[NUM_FLAGS-1:0];
    end
    nxt_flags = nxt_flags | event_set;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      status_flags_ff <= RST_FLAGS;
    end else begin
      status_flags_ff <= nxt_flags;
    end
  end

  // Level interrupt; wake request only while waiting, never in stop
  assign o_irq = |(status_flags_ff & irq_mask_ff);
  assign o_wake_request = o_irq && i_wait_mode && !i_stop_mode;

  // ==========================================================================
  // Read path: data stand in the cycle after the read strobe
  assign status_view = {sync_bus.level[SYNC_CMP2], sync_bus.level[SYNC_CMP1],
                        cmp1_drive_ff, offset_en_ff, 2'h0, status_flags_ff};

  always_comb begin
    unique case (i_addr)
      OFS_ANALOG_MUX: nxt_rdata = analog_mux_reg_ff;
      OFS_ANALOG_CONTROL: nxt_rdata = analog_control_reg_ff;
      OFS_ANALOG_STATUS: nxt_rdata = status_view;
      OFS_IRQ_MASK: nxt_rdata = {6'h00, irq_mask_ff};
      OFS_WATCHDOG_SECURITY: nxt_rdata = {7'h00, optional_features_ff};
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= i_rd ? nxt_rdata : 8'h00;
    end
  end

  assign o_rdata = rdata_ff;

  // ==========================================================================
  // Channel routing and sample selection
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_route_supply <= 1'b0;
      o_route_pin <= 4'h0;
      o_sel_direct <= 1'b0;
      o_sel_divided <= 1'b0;
      o_sel_temp_diode <= 1'b0;
      o_diode_bias_en <= 1'b0;
      o_comparator_input_swap <= 1'b0;
    end else begin
      o_route_supply <= supply_ref && (channel_select_bits == 4'h0);
      // Lowest set channel bit wins so two pins are never shorted
      o_route_pin <= channel_select_bits & (~channel_select_bits + 4'h1);
      o_sel_direct <= hold && !divided_hold;
      o_sel_divided <= divided_hold && !hold;
      o_sel_temp_diode <= hold && divided_hold;
      o_diode_bias_en <= hold && divided_hold;
      o_comparator_input_swap <= analog_mux_reg_ff[MUX_SWAP_BIT];
    end
  end

  // ==========================================================================
  // Sample capacitor offset, steered by the hold bits once active
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_offset_enable <= 1'b0;
      o_offset_hold <= 1'b0;
      o_offset_divided <= 1'b0;
    end else begin
      o_offset_enable <= optional_features_ff && offset_en_ff;
      o_offset_hold <= optional_features_ff && offset_en_ff && hold;
      o_offset_divided <= optional_features_ff && offset_en_ff
                          && divided_hold;
    end
  end

  // ==========================================================================
  // Ramp current source and discharge device
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_current_source_en <= 1'b0;
      o_discharge_en <= 1'b0;
    end else begin
      // Source off while discharging so the two never fight
      o_current_source_en <= ramp_source_enable && !conv_method_bit1
                             && !conv_method_bit2 && charge_enable
                             && !discharge_request;
      o_discharge_en <= ramp_source_enable && discharge_request;
    end
  end

  // ==========================================================================
  // Comparator 1 drive of the port pin and shared capture pin
  assign pb4_drive_on = optional_features_ff && cmp1_drive_ff;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_pb4_out <= 1'b0;
      o_timer_capture_event <= 1'b0;
    end else begin
      o_pb4_out <= pb4_drive_on ? (sync_bus.level[SYNC_CMP1] | i_pb4_data
                                   | i_timer_output_level)
                                : i_pb4_data;
      // Any change on the shared pin reaches the timer capture
      o_timer_capture_event <= sync_bus.change[SYNC_CAPTURE_PIN];
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  sequence s_mux_write(logic [7:0] v);
    wr_mux && (i_wdata == v);
  endsequence

  property p_supply_route;
    (supply_ref && channel_select_bits == 4'h0) |=> o_route_supply;
  endproperty
  a_supply_route: assert property (p_supply_route)
    else $error("supply route missing");

  property p_divided;
    s_mux_write(8'h51) |=> ##1 (o_sel_divided && !o_sel_direct
                                && o_route_pin == 4'h1);
  endproperty
  a_divided: assert property (p_divided)
    else $error("divided input not selected");

  property p_pin_route;
    (channel_select_bits != 4'h0)
      |=> (o_route_pin != 4'h0 && !o_route_supply);
  endproperty
  a_pin_route: assert property (p_pin_route)
    else $error("pin route missing");

  property p_wait_wake;
    (o_irq && i_wait_mode && !i_stop_mode) |-> o_wake_request;
  endproperty
  a_wait_wake: assert property (p_wait_wake)
    else $error("no wake in wait mode");

  property p_stop_nowake;
    i_stop_mode |-> !o_wake_request;
  endproperty
  a_stop_nowake: assert property (p_stop_nowake)
    else $error("wake in stop mode");

  property p_flag_set;
    sync_bus.rise[SYNC_CMP1] |=> status_flags_ff[STS_CMP1_FLAG_BIT];
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("comparator flag lost");

  property p_pin_or;
    (pb4_drive_on && $stable(pb4_drive_on) && i_timer_output_level)
      |=> o_pb4_out;
  endproperty
  a_pin_or: assert property (p_pin_or)
    else $error("pin output not forced by timer level");

  property p_opt_off;
    !optional_features_ff
      |=> (!o_offset_enable && o_pb4_out == $past(i_pb4_data));
  endproperty
  a_opt_off: assert property (p_opt_off)
    else $error("optional feature active while disabled");

  property p_ramp_off;
    !ramp_source_enable |=> (!o_current_source_en && !o_discharge_en);
  endproperty
  a_ramp_off: assert property (p_ramp_off)
    else $error("ramp device active while disabled");

  property p_source_on;
    (ramp_source_enable && charge_enable && !conv_method_bit1
     && !conv_method_bit2 && !discharge_request) |=> o_current_source_en;
  endproperty
  a_source_on: assert property (p_source_on)
    else $error("current source not driving");

  property p_diode;
    s_mux_write(8'hC0) |=> ##1 (o_sel_temp_diode && o_diode_bias_en) [*2];
  endproperty
  a_diode: assert property (p_diode)
    else $error("temperature diode not selected");

  property p_bias_only_diode;
    o_diode_bias_en |-> o_sel_temp_diode;
  endproperty
  a_bias_only_diode: assert property (p_bias_only_diode)
    else $error("diode bias without selection");

  property p_capture;
    sync_bus.change[SYNC_CAPTURE_PIN] |=> o_timer_capture_event;
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture event missing");

endmodule

// ### tb/test_analog_mux_comparator_control.sv
// Self-checking bench for the analog multiplex and comparator control block
module test_analog_mux_comparator_control;
  timeunit 1ns;
  timeprecision 1ps;
  import analog_ctl_pkg::*;

  // ==========================================================================
  // Stimulus and observed signals
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_cmp1_out = 1'b0;
  logic i_cmp2_out = 1'b0;
  logic i_capture_pin = 1'b0;
  logic i_wait_mode = 1'b0;
  logic i_stop_mode = 1'b0;
  logic i_pb4_data = 1'b0;
  logic i_timer_output_level = 1'b0;
  logic [DATA_W-1:0] o_rdata;
  logic o_irq, o_wake_request, o_route_supply, o_sel_direct, o_sel_divided;
  logic o_sel_temp_diode, o_diode_bias_en, o_comparator_input_swap;
  logic o_offset_enable, o_offset_hold, o_offset_divided;
  logic o_current_source_en, o_discharge_en, o_pb4_out;
  logic o_timer_capture_event;
  logic [3:0] o_route_pin;
  int errors = 0;
  int checks = 0;

  // 20 MHz core clock
  always #25 i_clock = ~i_clock;

  analog_mux_comparator_control analog_mux_comparator_control_i (
    .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cmp1_out(i_cmp1_out),
    .i_cmp2_out(i_cmp2_out), .i_capture_pin(i_capture_pin),
    .i_wait_mode(i_wait_mode), .i_stop_mode(i_stop_mode),
    .i_pb4_data(i_pb4_data), .i_timer_output_level(i_timer_output_level),
    .o_irq(o_irq), .o_wake_request(o_wake_request),
    .o_route_supply(o_route_supply), .o_route_pin(o_route_pin),
    .o_sel_direct(o_sel_direct), .o_sel_divided(o_sel_divided),
    .o_sel_temp_diode(o_sel_temp_diode), .o_diode_bias_en(o_diode_bias_en),
    .o_comparator_input_swap(o_comparator_input_swap),
    .o_offset_enable(o_offset_enable), .o_offset_hold(o_offset_hold),
    .o_offset_divided(o_offset_divided),
    .o_current_source_en(o_current_source_en),
    .o_discharge_en(o_discharge_en), .o_pb4_out(o_pb4_out),
    .o_timer_capture_event(o_timer_capture_event));

  // ==========================================================================
  // Bus cycles and comparisons
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [12:0] a, output logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  // Derived outputs follow a register two edges after the strobe
  task automatic settle(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string m);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp,
                          input string m);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic test_reset();
    logic [7:0] d;
    rd(OFS_ANALOG_MUX, d);
    chk_byte(d, 8'h00, "mux reset");
    rd(OFS_ANALOG_CONTROL, d);
    chk_byte(d, 8'h00, "control reset");
    rd(OFS_ANALOG_STATUS, d);
    chk_byte(d, 8'h00, "status reset");
    rd(OFS_WATCHDOG_SECURITY, d);
    chk_byte(d, 8'h00, "security reset");
    chk_bit(o_current_source_en | o_pb4_out | o_diode_bias_en, 1'b0,
            "outputs after reset");
    wr(13'h0100, 8'hFF);
    rd(13'h0100, d);
    chk_byte(d, 8'h00, "unmapped read");
    $display("test_reset done");
  endtask

  task automatic test_routing();
    logic [7:0] d;
    wr(OFS_ANALOG_MUX, 8'h20);
    settle(2);
    chk_bit(o_route_supply, 1'b1, "supply route");
    chk_byte({4'h0, o_route_pin}, 8'h00, "no pin with supply");
    for (int k = 0; k < 4; k++) begin
      wr(OFS_ANALOG_MUX, 8'h01 << k);
      settle(2);
      chk_byte({4'h0, o_route_pin}, 8'h01 << k, "pin route");
      chk_bit(o_route_supply, 1'b0, "supply off");
    end
    // Channel moves first, hold bits change only in later writes
    wr(OFS_ANALOG_MUX, 8'h11);
    wr(OFS_ANALOG_MUX, 8'h51);
    rd(OFS_ANALOG_MUX, d);
    chk_byte(d, 8'h51, "mux readback");
    settle(1);
    chk_bit(o_sel_divided, 1'b1, "divided select");
    chk_byte({4'h0, o_route_pin}, 8'h01, "divided keeps pin");
    chk_bit(o_comparator_input_swap, 1'b1, "input swap");
    wr(OFS_ANALOG_MUX, 8'h11);
    wr(OFS_ANALOG_MUX, 8'h00);
    wr(OFS_ANALOG_MUX, 8'h80);
    settle(2);
    chk_bit(o_sel_direct, 1'b1, "direct select");
    chk_bit(o_diode_bias_en, 1'b0, "bias off with hold only");
    wr(OFS_ANALOG_MUX, 8'hC0);
    settle(2);
    chk_bit(o_sel_temp_diode, 1'b1, "diode select");
    chk_bit(o_diode_bias_en, 1'b1, "bias on");
    wr(OFS_ANALOG_MUX, 8'h00);
    settle(2);
    chk_bit(o_diode_bias_en | o_sel_temp_diode, 1'b0, "bias off");
    $display("test_routing done");
  endtask

  task automatic test_ramp();
    logic [7:0] ctl [6] = '{8'h0C, 8'h0D, 8'h0E, 8'h04, 8'h18, 8'h10};
    logic [1:0] exp [6] = '{2'b10, 2'b00, 2'b00, 2'b00, 2'b01, 2'b00};
    for (int k = 0; k < 6; k++) begin
      wr(OFS_ANALOG_CONTROL, ctl[k]);
      settle(2);
      chk_byte({6'h00, o_current_source_en, o_discharge_en}, {6'h00, exp[k]},
               "ramp source outputs");
    end
    wr(OFS_ANALOG_CONTROL, 8'h00);
    $display("test_ramp done");
  endtask

  task automatic test_pin_drive();
    logic [2:0] v [4] = '{3'b100, 3'b010, 3'b001, 3'b000};
    // Comparator 1 pins stay plain inputs: only levels are driven
    wr(OFS_WATCHDOG_SECURITY, 8'h01);
    wr(OFS_ANALOG_STATUS, 8'h20);
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clock);
      i_cmp1_out <= v[k][2];
      i_pb4_data <= v[k][1];
      i_timer_output_level <= v[k][0];
      settle(6);
      chk_bit(o_pb4_out, |v[k], "pin is OR of sources");
    end
    wr(OFS_WATCHDOG_SECURITY, 8'h00);
    i_cmp1_out <= 1'b1;
    settle(6);
    chk_bit(o_pb4_out, 1'b0, "no drive without options");
    @(posedge i_clock);
    i_cmp1_out <= 1'b0;
    wr(OFS_ANALOG_STATUS, 8'h03);
    $display("test_pin_drive done");
  endtask

  task automatic test_irq();
    logic [7:0] d;
    int n;
    wr(OFS_IRQ_MASK, 8'h01);
    i_wait_mode <= 1'b1;
    i_cmp1_out <= 1'b1;
    n = 0;
    while (o_irq !== 1'b1 && n < 10) begin
      settle(1);
      n++;
    end
    if (n == 10) begin
      errors++;
      $display("[ERR] %0t comparator event timed out", $time);
      conclude();
    end
    chk_bit(o_irq, 1'b1, "irq on comparator 1 rise");
    chk_bit(o_wake_request, 1'b1, "wake in wait");
    @(posedge i_clock);
    i_stop_mode <= 1'b1;
    settle(1);
    chk_bit(o_wake_request, 1'b0, "no wake in stop");
    rd(OFS_ANALOG_STATUS, d);
    chk_byte(d, 8'h41, "status flag and level");
    wr(OFS_ANALOG_STATUS, 8'h01);
    settle(1);
    chk_bit(o_irq, 1'b0, "irq cleared");
    @(posedge i_clock);
    i_cmp2_out <= 1'b1;
    settle(6);
    chk_bit(o_irq, 1'b0, "masked comparator 2");
    wr(OFS_IRQ_MASK, 8'h03);
    settle(1);
    chk_bit(o_irq, 1'b1, "unmasked comparator 2");
    wr(OFS_ANALOG_STATUS, 8'h02);
    settle(1);
    chk_bit(o_irq, 1'b0, "comparator 2 cleared");
    i_stop_mode <= 1'b0;
    i_wait_mode <= 1'b0;
    $display("test_irq done");
  endtask

  task automatic test_capture();
    int n;
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clock);
      i_capture_pin <= ~i_capture_pin;
      n = 0;
      repeat (8) begin
        settle(1);
        n += int'(o_timer_capture_event === 1'b1);
      end
      chk_byte(8'(n), 8'h01, "one capture per change");
    end
    $display("test_capture done");
  endtask

  task automatic test_offset();
    wr(OFS_WATCHDOG_SECURITY, 8'h01);
    wr(OFS_ANALOG_STATUS, 8'h10);
    wr(OFS_ANALOG_MUX, 8'h80);
    settle(2);
    chk_byte({5'h00, o_offset_enable, o_offset_hold, o_offset_divided},
             8'h06, "offset by hold");
    wr(OFS_ANALOG_MUX, 8'h40);
    settle(2);
    chk_byte({5'h00, o_offset_enable, o_offset_hold, o_offset_divided},
             8'h05, "offset by divided hold");
    wr(OFS_WATCHDOG_SECURITY, 8'h00);
    settle(2);
    chk_byte({5'h00, o_offset_enable, o_offset_hold, o_offset_divided},
             8'h00, "offset off without options");
    $display("test_offset done");
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge i_clock);
    i_rst <= 1'b0;
    test_reset();
    test_routing();
    test_ramp();
    test_pin_drive();
    test_irq();
    test_capture();
    test_offset();
    conclude();
  end
endmodule
